//--- core/plf_params.svh
`ifndef PLF_PARAMS_SVH
`define PLF_PARAMS_SVH

// Bus addresses, read bit included, chosen by the address select pin
`define PLF_ADDR_AS_HIGH 8'h21
`define PLF_ADDR_AS_LOW 8'h23

// Output bytes per message and their index width
`define PLF_NUM_BYTES 7
`define PLF_IDX_W 3
`define PLF_LAST_IDX 3'h6
`define PLF_END_IDX 3'h7

// Source byte numbering of the decoded message
`define PLF_SRC_FIRST 13
`define PLF_SRC_LAST 25
`define PLF_SRC_IDX_W 5

// Source byte feeding the high and low nibble of output bytes one to six, and the high nibble of byte seven
`define PLF_SRC_B1_HI 16
`define PLF_SRC_B1_LO 17
`define PLF_SRC_B2_HI 18
`define PLF_SRC_B2_LO 19
`define PLF_SRC_B3_HI 20
`define PLF_SRC_B3_LO 21
`define PLF_SRC_B4_HI 22
`define PLF_SRC_B4_LO 23
`define PLF_SRC_B5_HI 14
`define PLF_SRC_B5_LO 15
`define PLF_SRC_B6_HI 24
`define PLF_SRC_B6_LO 25
`define PLF_SRC_B7_HI 13

// Padding and fill values
`define PLF_PAD_NIBBLE 4'hf
`define PLF_FILL_BYTE 8'hff

// Serial bit counting
`define PLF_BITS_PER_BYTE 4'h8
`define PLF_LAST_BIT 4'h7

// Reset values
`define PLF_RST_BYTE 8'h00
`define PLF_RST_NIBBLE 4'h0

`endif

//--- core/plf_pkg.sv
package plf_pkg;

   typedef logic [3:0] plf_nib_t;
   typedef logic [7:0] plf_byte_t;

   typedef enum logic [2:0] {
      PLF_IDLE,
      PLF_ADDR,
      PLF_ADDR_ACK,
      PLF_TX,
      PLF_TX_ACK
   } plf_bus_state_e;

endpackage : plf_pkg

//--- core/plf_out_mem.sv
`timescale 1ns/1ps

// Output byte bank, one write port and one registered read port
module plf_out_mem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 7,
   parameter int AW = 3
) (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic CLK_EN,
   input wire logic WR_EN,
   input wire logic [AW-1:0] WR_ADDR,
   input wire logic [WIDTH-1:0] WR_DATA,
   input wire logic RD_EN,
   input wire logic [AW-1:0] RD_ADDR,
   output logic [WIDTH-1:0] RD_DATA
);

   logic [WIDTH-1:0] mem_ff [0:DEPTH-1];

   always_ff @(posedge CLK) begin
      if (CLK_EN && WR_EN) begin
         mem_ff[WR_ADDR] <= WR_DATA;
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         RD_DATA <= '0;
      end else if (CLK_EN && RD_EN) begin
         RD_DATA <= mem_ff[RD_ADDR];
      end
   end

endmodule : plf_out_mem

//--- core/plf_label_formatter.sv
`timescale 1ns/1ps
`include "plf_params.svh"

// How it works
// - Seven output bytes go out in order, first to seventh, per read.
// - Byte one: source 16 then 17 nibbles, each bit-reversed.
// - Byte two: source 18 then 19 nibbles, each bit-reversed.
// - Byte three: source 20 then 21 nibbles, each bit-reversed.
// - Byte four: source 22 then 23 nibbles, each bit-reversed.
// - Byte five: source 14 then 15 nibbles, unallocated bits passed too.
// - Byte six: source 24 then 25 nibbles, each bit-reversed.
// - Byte seven: source 13 nibble reversed on top, low four bits ones.
// - Each byte is shifted out most significant bit first.
// - Read-only slave; address picked by select pin; write requests ignored.
// - Only error-free messages are copied; copy drives data available low.
module plf_label_formatter (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic CLK_EN,
   input wire logic SCL_IN,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   input wire logic ADDRESS_SELECT_PIN,
   output logic DATA_AVAILABLE_N,
   input wire logic MSG_WR,
   input wire logic [`PLF_SRC_IDX_W-1:0] MSG_IDX,
   input wire plf_pkg::plf_nib_t MSG_NIBBLE,
   input wire logic MSG_END,
   input wire logic MSG_BAD,
   output logic MSG_READY,
   output logic BUSY
);
   import plf_pkg::*;

   // Pin synchronisers and edge history
   logic scl_s1_ff, scl_s2_ff, scl_d_ff;
   logic sda_s1_ff, sda_s2_ff, sda_d_ff;
   logic sel_s1_ff, sel_s2_ff;
   logic scl_rise, scl_fall, bus_start, bus_stop;
   plf_byte_t own_addr;

   // Message staging and commit
   plf_nib_t src_ff [`PLF_SRC_FIRST:`PLF_SRC_LAST];
   logic pending_ff;
   logic commit_act_ff;
   logic [`PLF_IDX_W-1:0] commit_idx_ff;
   plf_byte_t commit_data;

   // Fetch and two-entry buffer
   logic [`PLF_IDX_W-1:0] rd_idx_ff;
   logic rd_pend_ff;
   logic fetch;
   plf_byte_t mem_rdata;
   plf_byte_t buf0_ff, buf1_ff;
   logic [1:0] buf_cnt_ff;
   logic buf_in_ready, buf_out_valid, buf_push, buf_pop;

   // Serial engine
   plf_bus_state_e state_ff;
   logic [3:0] bit_cnt_ff;
   plf_byte_t rx_sh_ff;
   plf_byte_t tx_sh_ff;
   logic ack_ff;
   logic load_evt, addr_hit;
   plf_byte_t next_byte;

   function automatic plf_nib_t rev_nib(input plf_nib_t n);
      rev_nib = {n[0], n[1], n[2], n[3]};
   endfunction : rev_nib

   function automatic plf_byte_t pack_byte(input plf_nib_t hi, input plf_nib_t lo);
      pack_byte = {rev_nib(hi), rev_nib(lo)};
   endfunction : pack_byte

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         scl_s1_ff <= 1'b1;
         scl_s2_ff <= 1'b1;
         scl_d_ff <= 1'b1;
         sda_s1_ff <= 1'b1;
         sda_s2_ff <= 1'b1;
         sda_d_ff <= 1'b1;
         sel_s1_ff <= 1'b1;
         sel_s2_ff <= 1'b1;
      end else if (CLK_EN) begin
         scl_s1_ff <= SCL_IN;
         scl_s2_ff <= scl_s1_ff;
         scl_d_ff <= scl_s2_ff;
         sda_s1_ff <= SDA_IN;
         sda_s2_ff <= sda_s1_ff;
         sda_d_ff <= sda_s2_ff;
         sel_s1_ff <= ADDRESS_SELECT_PIN;
         sel_s2_ff <= sel_s1_ff;
      end
   end

   assign scl_rise = scl_s2_ff & ~scl_d_ff;
   assign scl_fall = ~scl_s2_ff & scl_d_ff;
   assign bus_start = scl_s2_ff & scl_d_ff & sda_d_ff & ~sda_s2_ff;
   assign bus_stop = scl_s2_ff & scl_d_ff & ~sda_d_ff & sda_s2_ff;
   assign own_addr = sel_s2_ff ? `PLF_ADDR_AS_HIGH : `PLF_ADDR_AS_LOW;

   // Staging bank, refused while a finished message waits for its copy
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         for (int i = `PLF_SRC_FIRST; i <= `PLF_SRC_LAST; i++) begin
            src_ff[i] <= `PLF_RST_NIBBLE;
         end
      end else if (CLK_EN && MSG_WR && !pending_ff) begin
         if (MSG_IDX >= `PLF_SRC_IDX_W'(`PLF_SRC_FIRST) &&
             MSG_IDX <= `PLF_SRC_IDX_W'(`PLF_SRC_LAST)) begin
            src_ff[MSG_IDX] <= MSG_NIBBLE;
         end
      end
   end

   assign MSG_READY = ~pending_ff;

   // A bad message is simply dropped; staging is overwritten by the next one
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         pending_ff <= 1'b0;
      end else if (CLK_EN) begin
         if (commit_act_ff && commit_idx_ff == `PLF_LAST_IDX) begin
            pending_ff <= 1'b0;
         end else if (MSG_END && !MSG_BAD && !pending_ff) begin
            pending_ff <= 1'b1;
         end
      end
   end

   // Copy waits until no transfer is running
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         commit_act_ff <= 1'b0;
         commit_idx_ff <= '0;
      end else if (CLK_EN) begin
         if (commit_act_ff) begin
            commit_idx_ff <= commit_idx_ff + 1'b1;
            if (commit_idx_ff == `PLF_LAST_IDX) begin
               commit_act_ff <= 1'b0;
            end
         end else if (pending_ff && !BUSY) begin
            commit_act_ff <= 1'b1;
            commit_idx_ff <= '0;
         end
      end
   end

   always_comb begin
      case (commit_idx_ff)
         3'h0: commit_data = pack_byte(src_ff[`PLF_SRC_B1_HI], src_ff[`PLF_SRC_B1_LO]);
         3'h1: commit_data = pack_byte(src_ff[`PLF_SRC_B2_HI], src_ff[`PLF_SRC_B2_LO]);
         3'h2: commit_data = pack_byte(src_ff[`PLF_SRC_B3_HI], src_ff[`PLF_SRC_B3_LO]);
         3'h3: commit_data = pack_byte(src_ff[`PLF_SRC_B4_HI], src_ff[`PLF_SRC_B4_LO]);
         3'h4: commit_data = pack_byte(src_ff[`PLF_SRC_B5_HI], src_ff[`PLF_SRC_B5_LO]);
         3'h5: commit_data = pack_byte(src_ff[`PLF_SRC_B6_HI], src_ff[`PLF_SRC_B6_LO]);
         3'h6: commit_data = {rev_nib(src_ff[`PLF_SRC_B7_HI]), `PLF_PAD_NIBBLE};
         default: commit_data = `PLF_FILL_BYTE;
      endcase
   end

   // Copy wins over a read acknowledge landing in the same cycle
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         DATA_AVAILABLE_N <= 1'b1;
      end else if (CLK_EN) begin
         if (commit_act_ff && commit_idx_ff == `PLF_LAST_IDX) begin
            DATA_AVAILABLE_N <= 1'b0;
         end else if (addr_hit) begin
            DATA_AVAILABLE_N <= 1'b1;
         end
      end
   end

   plf_out_mem #(
      .WIDTH(8),
      .DEPTH(`PLF_NUM_BYTES),
      .AW(`PLF_IDX_W)
   ) u_out_mem (
      .CLK(CLK),
      .SYS_RST(SYS_RST),
      .CLK_EN(CLK_EN),
      .WR_EN(commit_act_ff),
      .WR_ADDR(commit_idx_ff),
      .WR_DATA(commit_data),
      .RD_EN(fetch),
      .RD_ADDR(rd_idx_ff),
      .RD_DATA(mem_rdata)
   );

   // Fetch holds off during a copy so one transfer never mixes messages
   assign fetch = BUSY && !commit_act_ff && !rd_pend_ff && buf_in_ready &&
                  rd_idx_ff != `PLF_END_IDX && !bus_start && !bus_stop;

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         rd_idx_ff <= '0;
         rd_pend_ff <= 1'b0;
      end else if (CLK_EN) begin
         if (bus_start || bus_stop) begin
            rd_idx_ff <= '0;
            rd_pend_ff <= 1'b0;
         end else begin
            rd_pend_ff <= fetch;
            if (fetch) begin
               rd_idx_ff <= rd_idx_ff + 1'b1;
            end
         end
      end
   end

   assign buf_in_ready = buf_cnt_ff != 2'h2;
   assign buf_out_valid = buf_cnt_ff != 2'h0;
   assign buf_push = rd_pend_ff;
   assign buf_pop = load_evt && buf_out_valid;

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         buf0_ff <= `PLF_RST_BYTE;
         buf1_ff <= `PLF_RST_BYTE;
         buf_cnt_ff <= 2'h0;
      end else if (CLK_EN) begin
         if (bus_start || bus_stop) begin
            buf_cnt_ff <= 2'h0;
         end else begin
            case ({buf_push, buf_pop})
               2'b10: begin
                  if (buf_cnt_ff == 2'h0) begin
                     buf0_ff <= mem_rdata;
                  end else begin
                     buf1_ff <= mem_rdata;
                  end
                  buf_cnt_ff <= buf_cnt_ff + 2'h1;
               end
               2'b01: begin
                  buf0_ff <= buf1_ff;
                  buf_cnt_ff <= buf_cnt_ff - 2'h1;
               end
               2'b11: begin
                  if (buf_cnt_ff == 2'h1) begin
                     buf0_ff <= mem_rdata;
                  end else begin
                     buf0_ff <= buf1_ff;
                     buf1_ff <= mem_rdata;
                  end
               end
               default: begin
                  buf_cnt_ff <= buf_cnt_ff;
               end
            endcase
         end
      end
   end

   // Serial engine
   assign addr_hit = state_ff == PLF_ADDR && scl_fall && bit_cnt_ff == `PLF_BITS_PER_BYTE &&
                     rx_sh_ff == own_addr;
   assign load_evt = scl_fall && !bus_start && !bus_stop &&
                     (state_ff == PLF_ADDR_ACK || (state_ff == PLF_TX_ACK && ack_ff));
   assign next_byte = buf_out_valid ? buf0_ff : `PLF_FILL_BYTE;
   assign BUSY = state_ff != PLF_IDLE;
   assign SDA_OUT = 1'b0;

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         state_ff <= PLF_IDLE;
         bit_cnt_ff <= 4'h0;
         rx_sh_ff <= `PLF_RST_BYTE;
         tx_sh_ff <= `PLF_FILL_BYTE;
         ack_ff <= 1'b0;
         SDA_OE <= 1'b0;
      end else if (CLK_EN) begin
         if (bus_start) begin
            state_ff <= PLF_ADDR;
            bit_cnt_ff <= 4'h0;
            SDA_OE <= 1'b0;
         end else if (bus_stop) begin
            state_ff <= PLF_IDLE;
            SDA_OE <= 1'b0;
         end else begin
            case (state_ff)
               PLF_ADDR: begin
                  if (scl_rise && bit_cnt_ff != `PLF_BITS_PER_BYTE) begin
                     rx_sh_ff <= {rx_sh_ff[6:0], sda_s2_ff};
                     bit_cnt_ff <= bit_cnt_ff + 4'h1;
                  end else if (scl_fall && bit_cnt_ff == `PLF_BITS_PER_BYTE) begin
                     if (addr_hit) begin
                        SDA_OE <= 1'b1;
                        state_ff <= PLF_ADDR_ACK;
                     end else begin
                        state_ff <= PLF_IDLE;
                     end
                  end
               end
               PLF_ADDR_ACK, PLF_TX_ACK: begin
                  if (scl_rise) begin
                     ack_ff <= ~sda_s2_ff;
                  end
                  if (load_evt) begin
                     tx_sh_ff <= next_byte;
                     SDA_OE <= ~next_byte[7];
                     bit_cnt_ff <= 4'h0;
                     state_ff <= PLF_TX;
                  end else if (scl_fall) begin
                     SDA_OE <= 1'b0;
                     state_ff <= PLF_IDLE;
                  end
               end
               PLF_TX: begin
                  if (scl_fall) begin
                     if (bit_cnt_ff == `PLF_LAST_BIT) begin
                        SDA_OE <= 1'b0;
                        ack_ff <= 1'b0;
                        state_ff <= PLF_TX_ACK;
                     end else begin
                        tx_sh_ff <= {tx_sh_ff[6:0], 1'b1};
                        SDA_OE <= ~tx_sh_ff[6];
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                     end
                  end
               end
               default: begin
                  SDA_OE <= 1'b0;
                  state_ff <= PLF_IDLE;
               end
            endcase
         end
      end
   end

endmodule : plf_label_formatter

//--- testbench/plf_label_formatter_properties.sv
`timescale 1ns/1ps
module plf_label_formatter_properties (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic CLK_EN,
   input wire logic SCL_IN,
   input wire logic SDA_OUT,
   input wire logic SDA_OE,
   input wire logic DATA_AVAILABLE_N,
   input wire logic MSG_END,
   input wire logic MSG_BAD,
   input wire logic MSG_READY,
   input wire logic BUSY
);
   logic pend_ff;
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   sequence good_end;
      MSG_END && !MSG_BAD && MSG_READY && CLK_EN;
   endsequence
   sequence quiet8;
      !BUSY [*8];
   endsequence
   // Remembers an accepted error-free message until the flag falls
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) pend_ff <= 1'b0;
      else if (MSG_END && !MSG_BAD && MSG_READY && CLK_EN) pend_ff <= 1'b1;
      else if ($fell(DATA_AVAILABLE_N)) pend_ff <= 1'b0;
   end
   chk_copy_flags: assert property (good_end ##1 quiet8 |-> ##[1:3] !DATA_AVAILABLE_N)
      else $error("flag not low after good message");
   chk_bad_silent: assert property ($fell(DATA_AVAILABLE_N) |-> pend_ff)
      else $error("flag fell without good message");
   chk_ready_drop: assert property (good_end |=> !MSG_READY)
      else $error("ready stayed high after message end");
   chk_ready_back: assert property (good_end ##1 quiet8 |-> ##[1:2] MSG_READY)
      else $error("ready not back after copy");
   chk_bit_timing: assert property ($changed(SDA_OE) |-> !SCL_IN)
      else $error("data line changed while bus clock high");
   chk_oe_busy: assert property (SDA_OE |-> BUSY)
      else $error("data line driven outside a transfer");
   chk_flag_hold: assert property (!DATA_AVAILABLE_N && !BUSY |=> !DATA_AVAILABLE_N)
      else $error("flag released without a read");
   chk_open_drain: assert property (SDA_OUT == 1'b0)
      else $error("data output value not low");
endmodule : plf_label_formatter_properties

//--- testbench/plf_i2c_master.sv
`timescale 1ns/1ps
module plf_i2c_master (
   input wire logic clk,
   input wire logic sda,
   output logic scl,
   output logic sda_pull
);
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   task automatic hp;
      repeat (8) @(negedge clk);
   endtask : hp
   // One bus clock pulse; d high releases the line, r is sampled late in the high phase
   task automatic bit_io(input logic d, output logic r);
      sda_pull = !d;
      hp();
      scl = 1'b1;
      hp();
      r = sda;
      scl = 1'b0;
      repeat (4) @(negedge clk);
   endtask : bit_io
   task automatic rd(input logic [7:0] a, input int n, output logic [7:0] q [0:6],
                     output logic ak);
      logic r;
      sda_pull = 1'b1;
      hp();
      scl = 1'b0;
      repeat (4) @(negedge clk);
      for (int i = 7; i >= 0; i--) bit_io(a[i], r);
      bit_io(1'b1, r);
      ak = !r;
      for (int k = 0; k < n && ak; k++) begin
         for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            q[k][i] = r;
         end
         bit_io(k == n - 1, r);
      end
      sda_pull = 1'b1;
      hp();
      scl = 1'b1;
      hp();
      sda_pull = 1'b0;
      hp();
   endtask : rd
endmodule : plf_i2c_master

//--- testbench/plf_label_formatter_tb.sv
`timescale 1ns/1ps
module plf_label_formatter_tb;
   logic clk = 0, rst = 1, sel_pin = 1, ce = 1, wr = 0, fin = 0, bad = 0, ak;
   logic [4:0] idx = 5'h0d;
   logic [3:0] nib = 4'h0;
   logic sda_oe, sda_out, avail_n, rdy, busy, scl, pull, sda;
   logic [3:0] stg [13:25], cur [13:25];
   logic [7:0] ev [0:6], got [0:6];
   int errors = 0, checked = 0, cyc = 0, seed = 32'h2315, t = 0;
   assign sda = !(sda_oe || pull);
   initial forever #12.5 clk = ~clk;
   plf_label_formatter uut (.CLK(clk), .SYS_RST(rst), .CLK_EN(ce), .SCL_IN(scl),
      .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .ADDRESS_SELECT_PIN(sel_pin),
      .DATA_AVAILABLE_N(avail_n), .MSG_WR(wr), .MSG_IDX(idx), .MSG_NIBBLE(nib),
      .MSG_END(fin), .MSG_BAD(bad), .MSG_READY(rdy), .BUSY(busy));
   plf_i2c_master m (.clk(clk), .sda(sda), .scl(scl), .sda_pull(pull));
   function automatic logic [3:0] rv(logic [3:0] n);
      return {n[0], n[1], n[2], n[3]};
   endfunction : rv
   task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
      checked++;
      if (s !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic snap;
      int hi [7] = '{16, 18, 20, 22, 14, 24, 13};
      for (int k = 0; k < 7; k++) ev[k] = {rv(cur[hi[k]]), k == 6 ? 4'hf : rv(cur[hi[k] + 1])};
   endtask : snap
   task automatic send(input logic b);
      for (int i = 0; i < 50 && !rdy; i++) @(negedge clk);
      for (int i = 13; i <= 25; i++) begin
         @(negedge clk);
         wr = 1;
         idx = 5'(i);
         nib = 4'($random(seed));
         stg[i] = nib;
      end
      @(negedge clk);
      wr = 0;
      fin = 1;
      bad = b;
      @(negedge clk);
      fin = 0;
      if (!b) cur = stg;
   endtask : send
   task automatic wait_avail;
      for (int i = 0; i < 30 && avail_n !== 1'b0; i++) @(negedge clk);
      chk("data_available_n", 8'(avail_n), 8'h0);
   endtask : wait_avail
   task automatic rdchk(input logic [7:0] a, input int n, input logic ea);
      m.rd(a, n, got, ak);
      chk("ack", 8'(ak), 8'(ea));
      for (int k = 0; k < n && ea; k++) chk("out_byte", got[k], ev[k]);
   endtask : rdchk
   task automatic done;
      t++;
      $display("test %0d done", t);
   endtask : done
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : tally_and_finish
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         errors++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (20) @(negedge clk);
      rst = 0;
      // Random messages, full read then a short one restarting at byte one
      for (int r = 0; r < 3; r++) begin
         send(0);
         wait_avail();
         snap();
         rdchk(8'h21, 7, 1);
         chk("data_available_n", 8'(avail_n), 8'h1);
         rdchk(8'h21, 2, 1);
      end
      done();
      send(1);
      repeat (30) @(negedge clk);
      chk("data_available_n", 8'(avail_n), 8'h1);
      // A good end while the clock enable is low must be ignored
      ce = 0;
      bad = 0;
      fin = 1;
      @(negedge clk);
      fin = 0;
      repeat (30) @(negedge clk);
      ce = 1;
      repeat (30) @(negedge clk);
      chk("data_available_n", 8'(avail_n), 8'h1);
      rdchk(8'h21, 7, 1);
      done();
      sel_pin = 0;
      rdchk(8'h21, 7, 0);
      rdchk(8'h22, 7, 0);
      rdchk(8'h23, 7, 1);
      done();
      // A message arriving mid-read must not alter the bytes being sent
      fork
         rdchk(8'h23, 7, 1);
         begin
            repeat (300) @(negedge clk);
            send(0);
         end
      join
      wait_avail();
      snap();
      rdchk(8'h23, 7, 1);
      done();
      tally_and_finish();
   end
endmodule : plf_label_formatter_tb
bind plf_label_formatter plf_label_formatter_properties chk_i (.CLK(CLK), .SYS_RST(SYS_RST),
   .CLK_EN(CLK_EN), .SCL_IN(SCL_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
   .DATA_AVAILABLE_N(DATA_AVAILABLE_N), .MSG_END(MSG_END), .MSG_BAD(MSG_BAD),
   .MSG_READY(MSG_READY), .BUSY(BUSY));
